// >>> rtl/dwsp_pkg.sv
package dwsp_pkg;

    // ========================================================================
    // frame layout
    localparam int FRAME_W    = 17;
    localparam int WIPER_W    = 8;
    localparam int STACK_POS  = 0;
    localparam int W1_MSB_POS = 1;
    localparam int W0_MSB_POS = 9;

    // ========================================================================
    // reset values
    localparam logic [7:0] WIPER_MID   = 8'h80;
    localparam logic       STACK_RESET = 1'h0;

    typedef logic [FRAME_W-1:0] dwsp_frame_t;

    typedef struct packed {
        logic             stack;
        logic [WIPER_W-1:0] w1;
        logic [WIPER_W-1:0] w0;
    } dwsp_settings_s;

    localparam dwsp_settings_s SETTINGS_INIT = '{
        stack: STACK_RESET,
        w1:    WIPER_MID,
        w0:    WIPER_MID
    };

    // ========================================================================
    // frame <-> settings; wiper msb sits at the lower frame position
    function automatic dwsp_settings_s dwsp_unpack(input dwsp_frame_t f);
        dwsp_settings_s s;
        s.stack = f[STACK_POS];
        s.w1    = '0;
        s.w0    = '0;
        for (int i = 0; i < WIPER_W; i++) begin
            s.w1[WIPER_W-1-i] = f[W1_MSB_POS+i];
            s.w0[WIPER_W-1-i] = f[W0_MSB_POS+i];
        end
        return s;
    endfunction

    function automatic dwsp_frame_t dwsp_pack(input dwsp_settings_s s);
        dwsp_frame_t f;
        f            = '0;
        f[STACK_POS] = s.stack;
        for (int i = 0; i < WIPER_W; i++) begin
            f[W1_MSB_POS+i] = s.w1[WIPER_W-1-i];
            f[W0_MSB_POS+i] = s.w0[WIPER_W-1-i];
        end
        return f;
    endfunction

    localparam dwsp_frame_t FRAME_INIT = dwsp_pack(SETTINGS_INIT);

endpackage

// >>> rtl/dwsp_sync.sv
`timescale 1ns/1ps
// two-flop level synchroniser; first stage is read only by the second
module dwsp_sync (
    // clock
    input  wire logic clk,
    // level
    input  wire logic d,
    output logic      q
);
    logic meta;
    logic next_meta;
    logic next_q;

    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge clk) begin
        meta <= next_meta;
        q    <= next_q;
    end
endmodule

// >>> rtl/dwsp_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - with select low the shift register ignores the serial clock until select rises; only the link reset reloads it.
// - while selected each rising serial clock shifts the data input in.
// - frame has 17 bits: 0 stack, 1..8 wiper one msb first, 9..16 zero.
// - frame order is stack bit, wiper one bits, then wiper zero bits.
// - select falling copies the frame into the latches, never earlier.
// - at power-up both wipers hold mid-scale code 1000 0000.
// - the stacked output follows wiper zero for stack 0, one for 1.
// - the chain output is the last stage, so the stack bit comes first.
// - the chain output is driven whatever the select level.
// - circulating 17 clocks per device restores the frame unchanged.
module dwsp_port
    import dwsp_pkg::*;
(
    // system side
    input  wire logic         clk,
    input  wire logic         rst,
    // serial link
    input  wire logic         link_clk,
    input  wire logic         link_select,
    input  wire logic         link_data,
    output logic              chain_shift_out,
    // wiper settings
    output logic [WIPER_W-1:0] wiper_zero_tap,
    output logic [WIPER_W-1:0] wiper_one_tap,
    output logic [WIPER_W-1:0] stacked_wiper_output,
    output logic              stack_select
);

    // ========================================================================
    // wiper shown at the stacked output for a set of latches
    function automatic logic [WIPER_W-1:0] stack_pick(
        input dwsp_settings_s s
    );
        return s.stack ? s.w1 : s.w0;
    endfunction

    // ========================================================================
    // reset handover: rst can be far shorter than a link clock period, so
    // the request stands until the link side answers through its own reset;
    // rst needs to stand only one clk cycle
    logic        rst_req;
    logic        next_rst_req;
    logic        rst_ack;
    logic        link_rst;

    dwsp_sync u_ack_sync (
        .clk (clk),
        .d   (link_rst),
        .q   (rst_ack)
    );

    always_comb begin
        next_rst_req = rst_req;
        if (rst) begin
            next_rst_req = 1'h1;
        end else if (rst_ack) begin
            next_rst_req = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        rst_req <= next_rst_req;
    end

    // ========================================================================
    // link domain: shift register on the serial clock
    dwsp_frame_t frame;
    dwsp_frame_t next_frame;

    dwsp_sync u_rst_sync (
        .clk (link_clk),
        .d   (rst_req),
        .q   (link_rst)
    );

    always_comb begin
        next_frame = frame;
        if (link_rst) begin
            next_frame = FRAME_INIT;
        end else if (link_select) begin
            // new bits enter at the top, stack bit ends at position 0
            next_frame = {link_data, frame[FRAME_W-1:1]};
        end
    end

    always_ff @(posedge link_clk) begin
        frame <= next_frame;
    end

    assign chain_shift_out = frame[STACK_POS];

    // ========================================================================
    // system domain: latch on deselect
    logic           sel_sync;
    logic           sel_prev;
    logic           next_sel_prev;
    logic           sel_fall;
    dwsp_settings_s settings;
    dwsp_settings_s next_settings;
    logic [WIPER_W-1:0] stacked;
    logic [WIPER_W-1:0] next_stacked;

    dwsp_sync u_sel_sync (
        .clk (clk),
        .d   (link_select),
        .q   (sel_sync)
    );

    // frame is frozen while select is low, so it is safe to read here
    assign sel_fall = sel_prev & ~sel_sync;

    always_comb begin
        next_sel_prev = sel_sync;
        next_settings = settings;
        next_stacked  = stack_pick(settings);
        if (rst) begin
            next_sel_prev = 1'h0;
            next_settings = SETTINGS_INIT;
            next_stacked  = WIPER_MID;
        end else if (sel_fall) begin
            next_settings = dwsp_unpack(frame);
        end
    end

    always_ff @(posedge clk) begin
        sel_prev <= next_sel_prev;
        settings <= next_settings;
        stacked  <= next_stacked;
    end

    assign wiper_zero_tap       = settings.w0;
    assign wiper_one_tap        = settings.w1;
    assign stack_select         = settings.stack;
    assign stacked_wiper_output = stacked;

    // ========================================================================
    // checks: link domain
    a_shift_entry: assert property (
        @(posedge link_clk) disable iff (link_rst)
        link_select |=> frame[FRAME_W-1] == $past(link_data)
                        && frame[FRAME_W-2:0] == $past(frame[FRAME_W-1:1]))
        else $error("frame did not shift in the data bit");

    a_idle_hold: assert property (
        @(posedge link_clk) disable iff (link_rst)
        !link_select && !link_rst |=> $stable(frame))
        else $error("frame changed while deselected");

    a_chain_next: assert property (
        @(posedge link_clk) disable iff (link_rst)
        link_select |=> chain_shift_out == $past(frame[STACK_POS+1]))
        else $error("chain output did not advance one stage");

    a_frame_init: assert property (
        @(posedge link_clk) disable iff (link_rst)
        $fell(link_rst) |-> frame == FRAME_INIT && !chain_shift_out)
        else $error("frame not initialised to latch values");

    a_reset_frame: assert property (
        @(posedge link_clk)
        link_rst |=> frame == FRAME_INIT)
        else $error("frame left its start value during reset");

    a_chain_hold: assert property (
        @(posedge link_clk) disable iff (link_rst)
        !link_select && !link_rst |=> $stable(chain_shift_out))
        else $error("chain output moved while deselected");

    // ========================================================================
    // checks: system domain
    sequence s_deselect;
        sel_prev ##0 !sel_sync;
    endsequence

    a_latch_deselect: assert property (
        @(posedge clk) disable iff (rst)
        s_deselect |=> settings == dwsp_unpack($past(frame)))
        else $error("latches did not load frame on deselect");

    a_no_early_load: assert property (
        @(posedge clk) disable iff (rst)
        !(sel_prev && !sel_sync) |=> $stable(settings))
        else $error("latches changed without a deselect");

    a_mid_reset: assert property (
        @(posedge clk) disable iff (rst)
        $fell(rst) |-> wiper_zero_tap == WIPER_MID
                       && wiper_one_tap == WIPER_MID && !stack_select)
        else $error("wipers not at mid-scale after reset");

    a_stack_mux: assert property (
        @(posedge clk) disable iff (rst)
        s_deselect ##1 1'b1 |=> stacked_wiper_output ==
            ($past(stack_select) ? $past(wiper_one_tap)
                                 : $past(wiper_zero_tap)))
        else $error("stacked output routed the wrong wiper");

    a_req_set: assert property (
        @(posedge clk)
        rst |=> rst_req)
        else $error("link reset request not raised");

    a_req_wait: assert property (
        @(posedge clk) disable iff (rst)
        rst_req && !rst_ack |=> rst_req)
        else $error("link reset request dropped before the answer");

    a_ack_clear: assert property (
        @(posedge clk) disable iff (rst)
        rst_ack |=> !rst_req)
        else $error("link reset request stayed after the answer");

    a_stack_follow: assert property (
        @(posedge clk) disable iff (rst)
        1'b1 |=> stacked_wiper_output == stack_pick($past(settings)))
        else $error("stacked output does not follow the latches");

endmodule

// >>> tb/dwsp_host.sv
`timescale 1ns/1ps
// ============================================================
// host on the serial link; link clock can keep pulsing between frames, with select low
module dwsp_host (
    // serial link
    output logic      link_clk,
    output logic      link_select,
    output logic      link_data,
    // loop back from the chain output
    input  wire logic chain_shift_out
);
    logic loop_back;
    logic hold;

    // released line shows a changing pattern, never the last bit
    assign link_data = loop_back ? chain_shift_out : hold;

    initial begin
        link_clk = 1'h0;
        link_select = 1'h0;
        loop_back = 1'h0;
        hold = 1'h0;
    end

    task automatic pulse();
        #80 link_clk = 1'h1;
        #80 link_clk = 1'h0;
    endtask

    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            hold = ~hold;
            pulse();
        end
    endtask

    // bits[0] leaves first; 17 edges a frame, select dropped promptly
    task automatic frame(input logic [16:0] bits, input logic loop);
        link_select = 1'h1;
        loop_back = loop;
        #80;
        for (int i = 0; i < 17; i++) begin
            hold = loop ? ~hold : bits[i];
            pulse();
        end
        loop_back = 1'h0;
        hold = ~hold;
        link_select = 1'h0;
        #200;
    endtask
endmodule

// >>> tb/test_dwsp_port.sv
`timescale 1ns/1ps
module test_dwsp_port;
    import dwsp_pkg::*;
    logic               clk, rst, link_clk, link_select, link_data;
    logic               chain_shift_out, stack_select, es;
    logic [WIPER_W-1:0] wiper_zero_tap, wiper_one_tap;
    logic [WIPER_W-1:0] stacked_wiper_output, e0, e1;
    int                 n_mismatch, n_checks, cycles;

    dwsp_port i_dwsp_port (.clk(clk), .rst(rst), .link_clk(link_clk),
        .link_select(link_select), .link_data(link_data),
        .chain_shift_out(chain_shift_out), .wiper_zero_tap(wiper_zero_tap),
        .wiper_one_tap(wiper_one_tap),
        .stacked_wiper_output(stacked_wiper_output),
        .stack_select(stack_select));
    dwsp_host i_host (.link_clk(link_clk), .link_select(link_select),
        .link_data(link_data), .chain_shift_out(chain_shift_out));

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic all(input string name);
        repeat (6) @(negedge clk);
        chk("stack", {7'h0, es}, {7'h0, stack_select});
        chk("wiper0", e0, wiper_zero_tap);
        chk("wiper1", e1, wiper_one_tap);
        chk("stacked", es ? e1 : e0, stacked_wiper_output);
        chk("chain", {7'h0, es}, {7'h0, chain_shift_out});
        $display("test %s done", name);
    endtask

    task automatic t_write(input logic s, input logic [7:0] w1, w0);
        logic [16:0] b;
        b[0] = s;
        for (int i = 0; i < 8; i++) begin
            b[1+i] = w1[7-i];
            b[9+i] = w0[7-i];
        end
        fork
            i_host.frame(b, 1'h0);
            #2000 chk("early load", e0, wiper_zero_tap);
        join
        es = s;
        e1 = w1;
        e0 = w0;
        all("write");
    endtask

    task automatic t_reset(input string name);
        rst = 1'h1;
        repeat (6) @(negedge clk);
        rst = 1'h0;
        i_host.idle(6);
        es = STACK_RESET;
        e0 = WIPER_MID;
        e1 = WIPER_MID;
        all(name);
    endtask

    initial begin
        rst = 1'h1;
        t_reset("reset");
        t_write(1'h1, 8'h3c, 8'ha5);
        t_write(1'h0, 8'h01, 8'hfe);
        i_host.idle(20);
        all("deselected clocks");
        i_host.frame(17'h0, 1'h1);
        all("read back");
        t_reset("mid-run reset");
        i_host.frame(17'h0, 1'h1);
        all("reset read back");
        results();
    end
endmodule
